//--- logic/cir_pkg.sv
`default_nettype none
package cir_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] INT_REG_OFFS = 12'h008;
    localparam logic [11:0] RST_REG_OFFS = 12'h00C;

    // ------------------------------------------------------------
    // Clock interrupt register fields
    // ------------------------------------------------------------
    localparam int OSC_COUNT = 6;
    localparam int FLAG_LO = 0;
    localparam int STUCK_FLAG_POS = 7;
    localparam int IRQ_EN_LO = 8;
    localparam int CLEAR_LO = 16;
    localparam int STUCK_CLEAR_POS = 23;
    localparam logic [5:0] IRQ_EN_RESET = 6'h00;
    localparam logic [6:0] FLAG_RESET = 7'h00;

    // ------------------------------------------------------------
    // Secondary bus reset register fields
    // ------------------------------------------------------------
    localparam int HOLD_GP_C = 18;
    localparam int HOLD_GP_B = 17;
    localparam int HOLD_GP_A = 16;
    localparam int HOLD_XCVR = 14;
    localparam int HOLD_SPI = 12;
    localparam int HOLD_ADV = 11;
    localparam int HOLD_CONV = 9;
    localparam int HOLD_SYSCFG = 0;
    localparam logic [31:0] RST_RW_MASK = 32'h0007_5A01;
    localparam logic [31:0] RST_RESET_VAL = 32'h0000_0000;

    // Bit i of the packed form is flag bit i of the interrupt register.
    typedef struct packed {
        logic fast_rc_osc;
        logic pll;
        logic hs_crystal_osc;
        logic rc8_osc;
        logic ls_crystal_osc;
        logic slow_rc_osc;
    } cir_osc_t;

    typedef struct packed {
        logic gp_timer_c_hold;
        logic gp_timer_b_hold;
        logic gp_timer_a_hold;
        logic serial_xcvr_hold;
        logic serial_periph_hold;
        logic adv_timer_hold;
        logic converter_hold;
        logic syscfg_comparator_hold;
    } cir_hold_t;

endpackage : cir_pkg
`default_nettype wire

//--- logic/cir_flag_cell.sv
`timescale 1ns/10ps
`default_nettype none
module cir_flag_cell (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Event source and control
    input wire logic raw_in,
    input wire logic enable,
    input wire logic clear,
    // Status
    output logic set_evt,
    output logic flag_q
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic flag_d;

    // ------------------------------------------------------------
    // Synchroniser and edge detect
    // ------------------------------------------------------------
    // The source level comes from another clock, so only the second
    // stage feeds the edge detector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            flag_q <= flag_d;
        end
    end

    assign set_evt = sync2_q & ~prev_q & enable;
    // A new event in the clearing cycle keeps the flag set.
    assign flag_d = set_evt | (flag_q & ~clear);

endmodule : cir_flag_cell
`default_nettype wire

//--- logic/cir_apb_decode.sv
`timescale 1ns/10ps
`default_nettype none
module cir_apb_decode (
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    // Decoded strobes
    output logic sel_int,
    output logic sel_rst,
    output logic wr_int,
    output logic wr_rst,
    output logic rd_setup,
    // APB answer
    output logic pready,
    output logic pslverr
);

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] offs);
        hit = (addr[11:2] == offs[11:2]);
    endfunction : hit

    logic access;

    assign sel_int = hit(paddr, cir_pkg::INT_REG_OFFS);
    assign sel_rst = hit(paddr, cir_pkg::RST_REG_OFFS);
    assign access = psel & penable;
    assign wr_int = access & pwrite & sel_int;
    assign wr_rst = access & pwrite & sel_rst;
    assign rd_setup = psel & ~penable & ~pwrite;
    // Zero wait states; read data is staged in the setup cycle.
    assign pready = 1'b1;
    assign pslverr = access & ~(sel_int | sel_rst);

endmodule : cir_apb_decode
`default_nettype wire

//--- logic/cir_clock_irq_reset.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - A stuck high-speed crystal clock sets the stuck-clock flag at bit 7 of the interrupt register.
// - The stuck-clock flag is cleared only by writing 1 to its clear bit.
// - The fast RC stable flag at bit 5 sets only on a stable report while its enable is 1.
// - The PLL lock flag at bit 4 sets only on a lock report while its enable is 1.
// - The high-speed crystal stable flag at bit 3 sets when it becomes stable while enabled.
// - The 8 MHz RC stable flag at bit 2 sets when it becomes stable while enabled.
// - The low-speed crystal stable flag at bit 1 sets when it becomes stable while enabled.
// - The slow RC stable flag at bit 0 sets when it becomes stable while enabled.
// - Each stable flag holds until its own clear bit is written with 1, which returns it to 0 unless a new event sets it in that same cycle.
// - Bit 8 of the interrupt register is the read-write slow RC stable interrupt enable.
// - Bits 18 to 16 of the reset register hold the three general timers in reset while 1.
// - Bits 14, 12, 11 and 9 hold the transceiver, serial port, advanced timer and converter.
// - Bit 0 of the reset register holds system configuration and comparator in reset.
// - Reserved bits read as their reset value and software writes them unchanged.
module cir_clock_irq_reset (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator status, asynchronous to pclk
    input wire cir_pkg::cir_osc_t osc_stable,
    input wire logic hs_crystal_stuck,
    // Peripheral reset holds and interrupt
    output cir_pkg::cir_hold_t periph_hold,
    output logic clk_irq
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic sel_int;
    logic sel_rst;
    logic wr_int;
    logic wr_rst;
    logic rd_setup;

    cir_apb_decode u_decode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .sel_int(sel_int),
        .sel_rst(sel_rst),
        .wr_int(wr_int),
        .wr_rst(wr_rst),
        .rd_setup(rd_setup),
        .pready(pready),
        .pslverr(pslverr)
    );

    // ------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------
    logic [5:0] irq_en_q;
    logic [5:0] irq_en_d;

    assign irq_en_d = wr_int ? pwdata[cir_pkg::IRQ_EN_LO +: cir_pkg::OSC_COUNT] : irq_en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= cir_pkg::IRQ_EN_RESET;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // Index 6 is the stuck-clock monitor; it has no enable of its own.
    logic [6:0] raw_vec;
    logic [6:0] en_vec;
    logic [6:0] clr_vec;
    logic [6:0] set_vec;
    logic [6:0] flag_q;

    assign raw_vec = {hs_crystal_stuck, osc_stable};
    assign en_vec = {1'b1, irq_en_q};
    // Only a written 1 clears; clear bits are never stored.
    assign clr_vec[5:0] = wr_int ? pwdata[cir_pkg::CLEAR_LO +: cir_pkg::OSC_COUNT] : 6'h00;
    assign clr_vec[6] = wr_int & pwdata[cir_pkg::STUCK_CLEAR_POS];

    for (genvar i = 0; i < 7; i++) begin : g_flag
        cir_flag_cell u_flag (
            .pclk(pclk),
            .presetn(presetn),
            .raw_in(raw_vec[i]),
            .enable(en_vec[i]),
            .clear(clr_vec[i]),
            .set_evt(set_vec[i]),
            .flag_q(flag_q[i])
        );
    end

    assign clk_irq = |flag_q;

    // ------------------------------------------------------------
    // Secondary bus reset register
    // ------------------------------------------------------------
    logic [31:0] rst_q;
    logic [31:0] rst_d;

    // Reserved bits are masked so they always read back as reset value.
    assign rst_d = wr_rst ? (pwdata & cir_pkg::RST_RW_MASK) : rst_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q <= cir_pkg::RST_RESET_VAL;
        end else begin
            rst_q <= rst_d;
        end
    end

    assign periph_hold.gp_timer_c_hold = rst_q[cir_pkg::HOLD_GP_C];
    assign periph_hold.gp_timer_b_hold = rst_q[cir_pkg::HOLD_GP_B];
    assign periph_hold.gp_timer_a_hold = rst_q[cir_pkg::HOLD_GP_A];
    assign periph_hold.serial_xcvr_hold = rst_q[cir_pkg::HOLD_XCVR];
    assign periph_hold.serial_periph_hold = rst_q[cir_pkg::HOLD_SPI];
    assign periph_hold.adv_timer_hold = rst_q[cir_pkg::HOLD_ADV];
    assign periph_hold.converter_hold = rst_q[cir_pkg::HOLD_CONV];
    assign periph_hold.syscfg_comparator_hold = rst_q[cir_pkg::HOLD_SYSCFG];

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Bit 6 and all clear bits read as 0.
    logic [31:0] int_rd;
    logic [31:0] rd_sel;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    assign int_rd = {16'h0000, 2'b00, irq_en_q, flag_q[6], 1'b0, flag_q[5:0]};
    assign rd_sel = sel_int ? int_rd : (sel_rst ? rst_q : 32'h0000_0000);
    assign prdata_d = rd_setup ? rd_sel : prdata_q;

    // Staging in the setup cycle keeps prdata on a flop with no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    stuck_flag_set_a: assert property (set_vec[6] |=> flag_q[6])
        else $error("stuck flag not set after monitor event");
    stuck_flag_hold_a: assert property (flag_q[6] && !clr_vec[6] |=> flag_q[6])
        else $error("stuck flag dropped without clear");
    fast_rc_gate_a: assert property ($rose(flag_q[5]) |-> $past(irq_en_q[5]))
        else $error("fast rc flag set while disabled");
    pll_lock_set_a: assert property (set_vec[4] |=> flag_q[4])
        else $error("pll lock flag missed");
    hs_crystal_idle_a: assert property (!irq_en_q[3] && !flag_q[3] |=> !flag_q[3])
        else $error("hs crystal flag set while disabled");
    rc8_set_en_a: assert property ($rose(flag_q[2]) |-> $past(irq_en_q[2]))
        else $error("rc8 set event without enable");
    ls_set_wins_a: assert property (set_vec[1] && clr_vec[1] |=> flag_q[1])
        else $error("ls crystal event lost to clear");
    slow_rc_stay_a: assert property (flag_q[0] && !clr_vec[0] |=> flag_q[0])
        else $error("slow rc flag dropped");
    flag_clear_a: assert property (clr_vec[2] && !set_vec[2] |=> !flag_q[2])
        else $error("rc8 flag not cleared");
    slow_en_write_a: assert property (wr_int |=> irq_en_q[0] == $past(pwdata[8]))
        else $error("slow rc enable not written");
    timer_hold_a: assert property (wr_rst |=> {periph_hold.gp_timer_c_hold,
        periph_hold.gp_timer_b_hold, periph_hold.gp_timer_a_hold} == $past(pwdata[18:16]))
        else $error("timer holds do not follow write");
    periph_hold_a: assert property (wr_rst |=> {periph_hold.serial_xcvr_hold,
        periph_hold.serial_periph_hold, periph_hold.adv_timer_hold,
        periph_hold.converter_hold} == {$past(pwdata[14]), $past(pwdata[12]),
        $past(pwdata[11]), $past(pwdata[9])})
        else $error("peripheral holds do not follow write");
    syscfg_hold_a: assert property (wr_rst ##1 !wr_rst |=>
        periph_hold.syscfg_comparator_hold == $past(pwdata[0], 2))
        else $error("syscfg hold not kept");
    reserved_zero_a: assert property (psel && penable && !pwrite && sel_rst |->
        (prdata & ~cir_pkg::RST_RW_MASK) == 32'h0000_0000)
        else $error("reserved reset bits read nonzero");
    irq_follow_a: assert property ((flag_q != 7'h00) == clk_irq)
        else $error("interrupt request does not match flags");

    // ------------------------------------------------------------
    // Flag set paths
    // ------------------------------------------------------------
    // An event that passes its enable shows in the flag at the next edge.
    fast_rc_set_a: assert property (
        set_vec[5] |=> flag_q[5])
        else $error("fast rc flag missed");
    hs_crystal_set_a: assert property (
        set_vec[3] |=> flag_q[3])
        else $error("hs crystal flag missed");
    rc8_set_a: assert property (
        set_vec[2] |=> flag_q[2])
        else $error("rc8 flag missed");
    ls_set_a: assert property (
        set_vec[1] |=> flag_q[1])
        else $error("ls crystal flag missed");
    slow_rc_set_a: assert property (
        set_vec[0] |=> flag_q[0])
        else $error("slow rc flag missed");
    stray_set_a: assert property (
        (flag_q & ~$past(flag_q) & ~$past(set_vec)) == 7'h00)
        else $error("flag rose without an event");

    // ------------------------------------------------------------
    // Enable gates
    // ------------------------------------------------------------
    // A disabled source may change level freely without touching its flag.
    fast_rc_idle_a: assert property (
        !irq_en_q[5] && !flag_q[5] |=> !flag_q[5])
        else $error("fast rc flag set while disabled");
    pll_lock_gate_a: assert property (
        $rose(flag_q[4]) |-> $past(irq_en_q[4]))
        else $error("pll lock flag set while disabled");
    pll_lock_idle_a: assert property (
        !irq_en_q[4] && !flag_q[4] |=> !flag_q[4])
        else $error("pll lock flag rose while disabled");
    hs_crystal_gate_a: assert property (
        $rose(flag_q[3]) |-> $past(irq_en_q[3]))
        else $error("hs crystal flag rose while disabled");
    rc8_idle_a: assert property (
        !irq_en_q[2] && !flag_q[2] |=> !flag_q[2])
        else $error("rc8 flag set while disabled");
    ls_gate_a: assert property (
        $rose(flag_q[1]) |-> $past(irq_en_q[1]))
        else $error("ls crystal flag set while disabled");
    slow_rc_gate_a: assert property (
        $rose(flag_q[0]) |-> $past(irq_en_q[0]))
        else $error("slow rc flag set while disabled");

    // ------------------------------------------------------------
    // Flag hold and clear
    // ------------------------------------------------------------
    // A flag drops only through its own clear bit, so a neighbour's clear leaves it.
    fast_rc_hold_a: assert property (
        flag_q[5] && !clr_vec[5] |=> flag_q[5])
        else $error("fast rc flag dropped");
    pll_lock_hold_a: assert property (
        flag_q[4] && !clr_vec[4] |=> flag_q[4])
        else $error("pll lock flag dropped");
    hs_crystal_hold_a: assert property (
        flag_q[3] && !clr_vec[3] |=> flag_q[3])
        else $error("hs crystal flag dropped");
    rc8_hold_a: assert property (
        flag_q[2] && !clr_vec[2] |=> flag_q[2])
        else $error("rc8 flag dropped");
    ls_hold_a: assert property (
        flag_q[1] && !clr_vec[1] |=> flag_q[1])
        else $error("ls crystal flag dropped");
    fast_rc_clear_a: assert property (
        clr_vec[5] && !set_vec[5] |=> !flag_q[5])
        else $error("fast rc flag not cleared");
    pll_lock_clear_a: assert property (
        clr_vec[4] && !set_vec[4] |=> !flag_q[4])
        else $error("pll lock flag not cleared");
    hs_crystal_clear_a: assert property (
        clr_vec[3] && !set_vec[3] |=> !flag_q[3])
        else $error("hs crystal flag not cleared");
    ls_clear_a: assert property (
        clr_vec[1] && !set_vec[1] |=> !flag_q[1])
        else $error("ls crystal flag not cleared");
    slow_rc_clear_a: assert property (
        clr_vec[0] && !set_vec[0] |=> !flag_q[0])
        else $error("slow rc flag not cleared");
    stuck_clear_a: assert property (
        clr_vec[6] && !set_vec[6] |=> !flag_q[6])
        else $error("stuck flag not cleared");

    // ------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------
    enable_keep_a: assert property (
        !wr_int |=> $stable(irq_en_q))
        else $error("enables changed without a write");
    enable_write_a: assert property (
        wr_int |=> irq_en_q == $past(pwdata[13:8]))
        else $error("enables do not follow write");
    rst_keep_a: assert property (
        !wr_rst |=> $stable(rst_q))
        else $error("reset register changed without a write");
    rst_reserved_a: assert property (
        (rst_q & ~cir_pkg::RST_RW_MASK) == 32'h0000_0000)
        else $error("reserved reset bits stored");

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Read data is staged at the setup edge, so it shows the state of the setup cycle.
    int_reserved_a: assert property (
        psel && penable && !pwrite && sel_int |-> (prdata & 32'hFFFF_C040) == 32'h0000_0000)
        else $error("reserved interrupt bits read nonzero");
    int_flags_read_a: assert property (
        psel && penable && !pwrite && sel_int |-> {prdata[7], prdata[5:0]} == $past(flag_q))
        else $error("flags read back wrong");
    int_enables_read_a: assert property (
        psel && penable && !pwrite && sel_int |-> prdata[13:8] == $past(irq_en_q))
        else $error("enables read back wrong");
    rst_read_a: assert property (
        psel && penable && !pwrite && sel_rst |-> prdata == $past(rst_q))
        else $error("reset register read back wrong");
    bus_ready_a: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    unmapped_err_a: assert property (
        psel && penable && !(sel_int || sel_rst) |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (
        psel && penable && (sel_int || sel_rst) |-> !pslverr)
        else $error("mapped access flagged as error");
    prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read setup");
    unmapped_read_a: assert property (
        psel && penable && !pwrite && !(sel_int || sel_rst) |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    irq_rise_a: assert property (
        $rose(clk_irq) |-> $past(set_vec != 7'h00))
        else $error("interrupt request rose without an event");
    irq_fall_a: assert property (
        $fell(clk_irq) |-> $past(clr_vec != 7'h00))
        else $error("interrupt request fell without a clear");

endmodule : cir_clock_irq_reset
`default_nettype wire

//--- bench/cir_clock_irq_reset_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cir_clock_irq_reset_tb;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [31:0] EN_ALL = 32'h0000_3F00;
    localparam logic [11:0] NO_REG = 12'h010;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cir_pkg::cir_osc_t osc_stable;
    logic hs_crystal_stuck;
    cir_pkg::cir_hold_t periph_hold;
    logic clk_irq;
    int errors;
    int check_count;
    int cycles;
    logic [31:0] rd;
    logic err;
    int hold_pos [8] = '{0, 9, 11, 12, 14, 16, 17, 18};

    cir_clock_irq_reset dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_stable(osc_stable),
        .hs_crystal_stuck(hs_crystal_stuck),
        .periph_hold(periph_hold),
        .clk_irq(clk_irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // An idle edge first, so a release and the next setup never share a time step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_check

    // Holds move on the access edge, so look at them half a cycle later.
    task automatic hold_check(input logic [31:0] exp);
        @(negedge pclk);
        check(32'(periph_hold), exp);
    endtask : hold_check

    // ------------------------------------------------------------
    // Clock, timeout and sequence
    // ------------------------------------------------------------
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        errors = 0;
        check_count = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        osc_stable = 6'h00;
        hs_crystal_stuck = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_check(cir_pkg::RST_REG_OFFS, 32'h0000_0000);
        rd_check(cir_pkg::INT_REG_OFFS, 32'h0000_0000);
        check(32'(periph_hold), 32'h0000_0000);
        apb(1'b1, cir_pkg::RST_REG_OFFS, 32'hFFFF_FFFF);
        rd_check(cir_pkg::RST_REG_OFFS, 32'h0007_5A01);
        check(32'(periph_hold), 32'h0000_00FF);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, cir_pkg::RST_REG_OFFS, 32'h1 << hold_pos[i]);
            hold_check(32'h1 << i);
            rd_check(cir_pkg::RST_REG_OFFS, 32'h1 << hold_pos[i]);
        end
        apb(1'b1, NO_REG, 32'hFFFF_FFFF);
        check(32'(err), 32'h1);
        rd_check(NO_REG, 32'h0000_0000);
        check(32'(err), 32'h1);
        rd_check(cir_pkg::RST_REG_OFFS, 32'h0004_0000);
        check(32'(err), 32'h0);
        // Reserved bit 6 and the clear bits must read back as zero.
        apb(1'b1, cir_pkg::INT_REG_OFFS, EN_ALL | 32'h0000_0040);
        rd_check(cir_pkg::INT_REG_OFFS, EN_ALL);
        for (int i = 0; i < 6; i++) begin
            osc_stable <= 6'h01 << i;
            repeat (6) @(posedge pclk);
            osc_stable <= 6'h00;
            rd_check(cir_pkg::INT_REG_OFFS, EN_ALL | (32'h1 << i));
            check(32'(clk_irq), 32'h1);
            apb(1'b1, cir_pkg::INT_REG_OFFS, EN_ALL);
            rd_check(cir_pkg::INT_REG_OFFS, EN_ALL | (32'h1 << i));
            apb(1'b1, cir_pkg::INT_REG_OFFS, EN_ALL | (32'h1 << (16 + i)));
            rd_check(cir_pkg::INT_REG_OFFS, EN_ALL);
            check(32'(clk_irq), 32'h0);
        end
        // The set pulse meets the clear write at the same edge, and the set wins.
        osc_stable <= 6'h02;
        apb(1'b1, cir_pkg::INT_REG_OFFS, EN_ALL | 32'h0002_0000);
        osc_stable <= 6'h00;
        rd_check(cir_pkg::INT_REG_OFFS, EN_ALL | 32'h0000_0002);
        apb(1'b1, cir_pkg::INT_REG_OFFS, EN_ALL | 32'h0002_0000);
        rd_check(cir_pkg::INT_REG_OFFS, EN_ALL);
        // With every enable off no stabilization flag may set.
        apb(1'b1, cir_pkg::INT_REG_OFFS, 32'h0000_0000);
        osc_stable <= 6'h3F;
        repeat (6) @(posedge pclk);
        rd_check(cir_pkg::INT_REG_OFFS, 32'h0000_0000);
        check(32'(clk_irq), 32'h0);
        osc_stable <= 6'h00;
        hs_crystal_stuck <= 1'b1;
        repeat (6) @(posedge pclk);
        hs_crystal_stuck <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_check(cir_pkg::INT_REG_OFFS, 32'h0000_0080);
        check(32'(clk_irq), 32'h1);
        apb(1'b1, cir_pkg::INT_REG_OFFS, 32'h003F_0000);
        rd_check(cir_pkg::INT_REG_OFFS, 32'h0000_0080);
        apb(1'b1, cir_pkg::INT_REG_OFFS, 32'h0080_0000);
        rd_check(cir_pkg::INT_REG_OFFS, 32'h0000_0000);
        check(32'(clk_irq), 32'h0);
        // A reset in mid-run must drop every hold at once.
        apb(1'b1, cir_pkg::RST_REG_OFFS, 32'h0007_5A01);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        check(32'(periph_hold), 32'h0000_0000);
        presetn <= 1'b1;
        rd_check(cir_pkg::RST_REG_OFFS, 32'h0000_0000);
        give_verdict();
    end

endmodule : cir_clock_irq_reset_tb
`default_nettype wire
